// ==== design/emd_pkg.sv ====
`default_nettype none
// Shared definitions for both ends of the MAC data link.
package emd_pkg;

    // Interface modes; code 2'b10 is never used.
    typedef enum logic [1:0] {
        EMD_MII = 2'b00,
        EMD_RMII = 2'b01,
        EMD_SER = 2'b11
    } emd_mode_type;

    // Device start-up phases.
    typedef enum logic {
        EMD_ST_STRAP = 1'b0,
        EMD_ST_RUN = 1'b1
    } emd_phase_type;

    // Width of the clock generator half-period counter.
    localparam int EMD_CW = 8;
    // System clock period in ns.
    localparam int EMD_CLK_SYS_NS = 40;
    // Link clock periods in ns, as printed.
    localparam int EMD_MII100_NS = 40;
    localparam int EMD_MII10_NS = 400;
    localparam int EMD_SER_NS = 100;
    // Half periods in system cycles, rounded down, never below one.
    localparam logic [7:0] EMD_MII100_HALF = (EMD_MII100_NS / (2 *
        EMD_CLK_SYS_NS)) < 1 ? 8'h01 : 8'(EMD_MII100_NS / (2 * EMD_CLK_SYS_NS));
    localparam logic [7:0] EMD_MII10_HALF = (EMD_MII10_NS / (2 *
        EMD_CLK_SYS_NS)) < 1 ? 8'h01 : 8'(EMD_MII10_NS / (2 * EMD_CLK_SYS_NS));
    localparam logic [7:0] EMD_SER_HALF = (EMD_SER_NS / (2 *
        EMD_CLK_SYS_NS)) < 1 ? 8'h01 : 8'(EMD_SER_NS / (2 * EMD_CLK_SYS_NS));
    // The reference cannot run at its true rate off a 25 MHz clock, so it
    // is slowed to leave room for the device's input synchroniser.
    localparam logic [7:0] EMD_RMII_REF_HALF = 8'h04;
    // Cycles waited after reset before the straps are taken.
    localparam logic [1:0] EMD_STRAP_WAIT = 2'h2;
    // Pattern folded into receive data on a line error.
    localparam logic [3:0] EMD_RX_CORRUPT = 4'hF;

    // Index of the last beat of a nibble in each mode.
    function automatic logic [1:0] emd_last(input emd_mode_type m);
        unique case (m)
            EMD_MII: return 2'h0;
            EMD_RMII: return 2'h1;
            EMD_SER: return 2'h3;
            default: return 2'h0;
        endcase
    endfunction

    // Lane bits of a nibble for the current beat, low bits first.
    function automatic logic [3:0] emd_lane(input emd_mode_type m,
                                            input logic [3:0] d);
        unique case (m)
            EMD_MII: return d;
            EMD_RMII: return {2'h0, d[1:0]};
            EMD_SER: return {3'h0, d[0]};
            default: return d;
        endcase
    endfunction

    // Drop the lane just sent.
    function automatic logic [3:0] emd_shift(input emd_mode_type m,
                                             input logic [3:0] d);
        unique case (m)
            EMD_MII: return d;
            EMD_RMII: return {2'h0, d[3:2]};
            EMD_SER: return {1'h0, d[3:1]};
            default: return d;
        endcase
    endfunction

    // Gather one lane into a nibble, first lane ending lowest.
    function automatic logic [3:0] emd_pack(input emd_mode_type m,
                                            input logic [3:0] acc,
                                            input logic [3:0] d);
        unique case (m)
            EMD_MII: return d;
            EMD_RMII: return {d[1:0], acc[3:2]};
            EMD_SER: return {d[0], acc[3:1]};
            default: return d;
        endcase
    endfunction

endpackage
`default_nettype wire

// ==== design/emd_if.sv ====
`timescale 1ns/10ps
`default_nettype none
// Pins between the transceiver and the MAC.
interface emd_if;
    logic tx_clk; // Transmit clock from the device.
    logic tx_en; // Transmit enable from the MAC.
    logic [3:0] txd; // Transmit data from the MAC.
    logic rx_clk; // Receive clock from the device.
    logic rx_dv; // Receive data valid.
    logic rx_er; // Receive error.
    logic [3:0] rxd; // Receive data.
    logic crs; // Carrier sense, or carrier and valid combined.
    logic ref_clock_in; // Shared reference, made by the MAC side.

    // Device end.
    modport dev (
        output tx_clk, rx_clk, rx_dv, rx_er, rxd, crs,
        input tx_en, txd, ref_clock_in
    );

    // MAC end.
    modport mac (
        input tx_clk, rx_clk, rx_dv, rx_er, rxd, crs,
        output tx_en, txd, ref_clock_in
    );
endinterface
`default_nettype wire

// ==== design/emd_clkgen.sv ====
`timescale 1ns/10ps
`default_nettype none
// Divided square wave with one-cycle pulses on each edge of it.
module emd_clkgen #(
    parameter int CW = 8
) (
    // Clock, reset and enable.
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    // Control.
    input wire logic run,
    input wire logic [CW-1:0] half,
    // Outputs, all registered.
    output logic level,
    output logic rise,
    output logic fall
);

    typedef struct packed {
        logic [CW-1:0] cnt; // Cycles spent in this half period.
        logic level; // Clock level.
        logic rise; // Level went high at this edge.
        logic fall; // Level went low at this edge.
    } emd_gen_type;

    emd_gen_type s;
    emd_gen_type next_s;

    // Stopped generator parks low so a stop never leaves a stray high.
    always_comb begin
        next_s = s;
        next_s.rise = 1'b0;
        next_s.fall = 1'b0;
        if (!run) begin
            next_s.cnt = '0;
            next_s.level = 1'b0;
        end else if (s.cnt >= half - 1'b1) begin
            next_s.cnt = '0;
            next_s.level = !s.level;
            next_s.rise = !s.level;
            next_s.fall = s.level;
        end else begin
            next_s.cnt = s.cnt + 1'b1;
        end
    end

    // State register, frozen while the enable is low.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s <= '0;
        end else if (ce) begin
            s <= next_s;
        end
    end

    assign level = s.level;
    assign rise = s.rise;
    assign fall = s.fall;

endmodule
`default_nettype wire

// ==== design/emd_mac_host.sv ====
`timescale 1ns/10ps
`default_nettype none
// MAC end of the data link.
module emd_mac_host
    import emd_pkg::*;
#(
    parameter logic [7:0] REF_HALF = EMD_RMII_REF_HALF
) (
    // System clock, reset and enable.
    input wire logic CLK_SYS,
    input wire logic RSTN,
    input wire logic CE,
    // Mode, must match the device straps.
    input wire logic MODE_RMII,
    input wire logic MODE_SERIAL,
    // Transmit nibbles from the user.
    input wire logic [3:0] TX_DATA,
    input wire logic TX_VALID,
    output logic TX_TAKE,
    // Receive nibbles to the user.
    output logic [3:0] RX_DATA,
    output logic RX_VALID,
    output logic RX_ERR,
    output logic RX_CARRIER,
    // Link pins.
    emd_if.mac link
);

    typedef struct packed {
        logic tx_clk_prev; // Last seen transmit clock.
        logic rx_clk_prev; // Last seen receive clock.
        logic [3:0] txd; // Driven transmit lanes.
        logic tx_en; // Driven transmit enable.
        logic [3:0] tx_sh; // Lanes still to send.
        logic [1:0] tx_cnt; // Beats left in the nibble.
        logic tx_take; // Nibble taken pulse.
        logic [3:0] rx_sh; // Lanes gathered so far.
        logic [1:0] rx_cnt; // Beats gathered so far.
        logic rx_bad; // Error seen within the nibble.
        logic [3:0] rx_data; // Last whole nibble.
        logic rx_valid; // Whole nibble pulse.
        logic rx_err; // Error flag of that nibble.
        logic rx_carrier; // Sampled carrier sense.
    } emd_host_type;

    emd_host_type s;
    emd_host_type next_s;
    emd_mode_type mode;
    logic ref_level;
    logic ref_fall;
    logic launch;
    logic sample;
    logic rx_ok;

    assign mode = MODE_SERIAL ? EMD_SER : (MODE_RMII ? EMD_RMII : EMD_MII);

    // Reference for the shared-clock mode, stopped otherwise.
    emd_clkgen #(.CW(EMD_CW)) u_ref (
        .clk(CLK_SYS),
        .rst_n(RSTN),
        .ce(CE),
        .run(mode == EMD_RMII),
        .half(REF_HALF),
        .level(ref_level),
        .rise(),
        .fall(ref_fall)
    );

    // Launch off the device clock, or off the reference falling edge so
    // that data is steady when the device sees the rising one.
    assign launch = (mode == EMD_RMII) ? ref_fall :
        (link.tx_clk && !s.tx_clk_prev);
    assign sample = (mode == EMD_RMII) ? ref_fall :
        (link.rx_clk && !s.rx_clk_prev);
    assign rx_ok = (mode == EMD_SER) ? link.crs : link.rx_dv;

    // Transmit lanes out, receive lanes in.
    always_comb begin
        next_s = s;
        next_s.tx_clk_prev = link.tx_clk;
        next_s.rx_clk_prev = link.rx_clk;
        next_s.tx_take = 1'b0;
        next_s.rx_valid = 1'b0;
        if (launch) begin
            if (s.tx_cnt == 2'h0) begin
                // Enable stands exactly while a nibble is on the lanes.
                next_s.tx_en = TX_VALID;
                next_s.tx_take = TX_VALID;
                next_s.txd = TX_VALID ? emd_lane(mode, TX_DATA) : 4'h0;
                next_s.tx_sh = emd_shift(mode, TX_DATA);
                next_s.tx_cnt = TX_VALID ? emd_last(mode) : 2'h0;
            end else begin
                next_s.txd = emd_lane(mode, s.tx_sh);
                next_s.tx_sh = emd_shift(mode, s.tx_sh);
                next_s.tx_cnt = s.tx_cnt - 2'h1;
            end
        end
        if (sample) begin
            next_s.rx_carrier = link.crs;
            if (rx_ok) begin
                next_s.rx_sh = emd_pack(mode, s.rx_sh, link.rxd);
                next_s.rx_bad = ((s.rx_cnt != 2'h0) && s.rx_bad) ||
                    link.rx_er;
                if (s.rx_cnt == emd_last(mode)) begin
                    next_s.rx_data = next_s.rx_sh;
                    next_s.rx_err = next_s.rx_bad;
                    next_s.rx_valid = 1'b1;
                    next_s.rx_cnt = 2'h0;
                end else begin
                    next_s.rx_cnt = s.rx_cnt + 2'h1;
                end
            end else begin
                // A partial nibble is dropped when the frame ends.
                next_s.rx_cnt = 2'h0;
                next_s.rx_bad = 1'b0;
            end
        end
    end

    // State register.
    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            s <= '0;
        end else if (CE) begin
            s <= next_s;
        end
    end

    assign link.tx_en = s.tx_en;
    assign link.txd = s.txd;
    assign link.ref_clock_in = ref_level;
    assign TX_TAKE = s.tx_take;
    assign RX_DATA = s.rx_data;
    assign RX_VALID = s.rx_valid;
    assign RX_ERR = s.rx_err;
    assign RX_CARRIER = s.rx_carrier;

endmodule
`default_nettype wire

// ==== design/emd_phy_dev.sv ====
`timescale 1ns/10ps
`default_nettype none
module emd_phy_dev
    import emd_pkg::*;
#(
    parameter logic [7:0] MII100_HALF = EMD_MII100_HALF,
    parameter logic [7:0] MII10_HALF = EMD_MII10_HALF,
    parameter logic [7:0] SER_HALF = EMD_SER_HALF
) (
    // System clock, reset and enable.
    input wire logic CLK_SYS,
    input wire logic RSTN,
    input wire logic CE,
    // Mode straps, pins outside this clock domain.
    input wire logic STRAP_RMII,
    input wire logic STRAP_SERIAL,
    // Line status.
    input wire logic SPEED_100,
    input wire logic LINE_CARRIER,
    // Received nibbles from the line decoder.
    input wire logic LINE_RX_VALID,
    input wire logic LINE_RX_ERR,
    input wire logic [3:0] LINE_RX_DATA,
    output logic LINE_RX_TAKE,
    // Transmitted nibbles to the line encoder.
    output logic [3:0] LINE_TX_DATA,
    output logic LINE_TX_VALID,
    output logic LINE_TX_ACTIVE,
    // Latched interface mode.
    output emd_mode_type MODE,
    // Link pins.
    emd_if.dev link
);

    typedef struct packed {
        logic [1:0] strap_s1; // Strap synchroniser, first stage.
        logic [1:0] strap_s2; // Strap synchroniser, second stage.
        logic ref_s1; // Reference synchroniser, first stage.
        logic ref_s2; // Reference synchroniser, second stage.
        logic ref_prev; // Reference one cycle older, for edge finding.
        emd_phase_type phase; // Start-up phase.
        logic [1:0] wait_cnt; // Cycles since reset release.
        emd_mode_type mode; // Interface mode.
        logic [3:0] rxd; // Driven receive lanes.
        logic rx_dv; // Driven receive valid.
        logic rx_er; // Driven receive error.
        logic crs; // Driven carrier sense pin.
        logic [3:0] rx_sh; // Lanes still to send.
        logic [1:0] rx_cnt; // Beats left in the nibble.
        logic rx_take; // Line nibble consumed pulse.
        logic [3:0] tx_sh; // Lanes gathered so far.
        logic [1:0] tx_cnt; // Beats gathered so far.
        logic [3:0] tx_data; // Last whole transmit nibble.
        logic tx_valid; // Whole transmit nibble pulse.
        logic tx_active; // Transmit enable seen at the last beat.
    } emd_dev_type;

    emd_dev_type s;
    emd_dev_type next_s;
    logic clk_run;
    logic [7:0] clk_half;
    logic tx_clk_q;
    logic rx_clk_q;
    logic tx_rise;
    logic rx_rise;
    logic ref_rise;
    logic tx_beat;
    logic rx_beat;
    logic fast;
    logic rx_act;
    logic rx_bad;
    logic [3:0] rx_word;

    // Straps pick the mode; both straps rest low for MII.
    function automatic emd_mode_type strap_mode(input logic [1:0] st);
        if (st[1]) begin
            return EMD_SER;
        end else if (st[0]) begin
            return EMD_RMII;
        end else begin
            return EMD_MII;
        end
    endfunction

    // Clock pins run only in the modes that own them.
    assign clk_run = (s.phase == EMD_ST_RUN) &&
        (s.mode != EMD_RMII);
    // Serial mode has one fixed rate; MII follows the line speed.
    assign clk_half = (s.mode == EMD_SER) ? SER_HALF :
        (SPEED_100 ? MII100_HALF : MII10_HALF);

    // Transmit clock generator.
    emd_clkgen #(.CW(EMD_CW)) u_tx_clk (
        .clk(CLK_SYS),
        .rst_n(RSTN),
        .ce(CE),
        .run(clk_run),
        .half(clk_half),
        .level(tx_clk_q),
        .rise(tx_rise),
        .fall()
    );

    // Receive clock generator; the recovered clock is modelled as a
    // second divider locked to the same rate, with no phase drift.
    emd_clkgen #(.CW(EMD_CW)) u_rx_clk (
        .clk(CLK_SYS),
        .rst_n(RSTN),
        .ce(CE),
        .run(clk_run),
        .half(clk_half),
        .level(rx_clk_q),
        .rise(rx_rise),
        .fall()
    );

    // Reference edge found on the second stage only.
    assign ref_rise = s.ref_s2 && !s.ref_prev;
    // In RMII both directions step on the reference.
    assign tx_beat = (s.mode == EMD_RMII) ? ref_rise : tx_rise;
    assign rx_beat = (s.mode == EMD_RMII) ? ref_rise : rx_rise;
    // Serial mode is always the slow rate.
    assign fast = SPEED_100 && (s.mode != EMD_SER);
    // Serial frames on carrier, the others on receive valid.
    assign rx_act = (s.mode == EMD_SER) ? LINE_CARRIER : LINE_RX_VALID;
    // Errors count only inside a packet at the fast rate.
    assign rx_bad = LINE_RX_ERR && LINE_RX_VALID && fast;
    // Spoiled data keeps a MAC that ignores the error pin safe.
    assign rx_word = rx_bad ? (LINE_RX_DATA ^ EMD_RX_CORRUPT) :
        LINE_RX_DATA;

    // Start-up, then receive lanes out and transmit lanes in.
    always_comb begin
        next_s = s;
        next_s.rx_take = 1'b0;
        next_s.tx_valid = 1'b0;
        next_s.strap_s1 = {STRAP_SERIAL, STRAP_RMII};
        next_s.strap_s2 = s.strap_s1;
        next_s.ref_s1 = link.ref_clock_in;
        next_s.ref_s2 = s.ref_s1;
        next_s.ref_prev = s.ref_s2;
        unique case (s.phase)
            EMD_ST_STRAP: begin
                // Wait for the synchroniser to fill before trusting it.
                if (s.wait_cnt == EMD_STRAP_WAIT) begin
                    next_s.phase = EMD_ST_RUN;
                    next_s.mode = strap_mode(s.strap_s2);
                end else begin
                    next_s.wait_cnt = s.wait_cnt + 2'h1;
                end
            end
            EMD_ST_RUN: begin
                // Mode is not touched here, so it holds until reset.
                if (rx_beat) begin
                    if (s.rx_cnt == 2'h0) begin
                        // Start a nibble only while the frame is live.
                        next_s.rx_take = rx_act;
                        next_s.rx_sh = emd_shift(s.mode, rx_word);
                        next_s.rx_cnt = rx_act ? emd_last(s.mode) : 2'h0;
                        next_s.rxd = rx_act ?
                            emd_lane(s.mode, rx_word) : 4'h0;
                        // Serial mode leaves valid and error low.
                        next_s.rx_dv = LINE_RX_VALID &&
                            (s.mode != EMD_SER);
                        next_s.rx_er = rx_bad && (s.mode != EMD_SER);
                    end else begin
                        // Later lanes of the same nibble.
                        next_s.rxd = emd_lane(s.mode, s.rx_sh);
                        next_s.rx_sh = emd_shift(s.mode, s.rx_sh);
                        next_s.rx_cnt = s.rx_cnt - 2'h1;
                    end
                    // RMII folds valid into the carrier pin.
                    next_s.crs = LINE_CARRIER ||
                        ((s.mode == EMD_RMII) && next_s.rx_dv);
                end
                if (tx_beat) begin
                    next_s.tx_active = link.tx_en;
                    if (link.tx_en) begin
                        next_s.tx_sh = emd_pack(s.mode, s.tx_sh,
                            link.txd);
                        if (s.tx_cnt == emd_last(s.mode)) begin
                            next_s.tx_data = next_s.tx_sh;
                            next_s.tx_valid = 1'b1;
                            next_s.tx_cnt = 2'h0;
                        end else begin
                            next_s.tx_cnt = s.tx_cnt + 2'h1;
                        end
                    end else begin
                        // A partial nibble at frame end is dropped.
                        next_s.tx_cnt = 2'h0;
                    end
                end
            end
        endcase
    end

    // State register; asynchronous reset to constants only.
    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            s <= '0;
        end else if (CE) begin
            s <= next_s;
        end
    end

    assign link.tx_clk = tx_clk_q;
    assign link.rx_clk = rx_clk_q;
    assign link.rxd = s.rxd;
    assign link.rx_dv = s.rx_dv;
    assign link.rx_er = s.rx_er;
    assign link.crs = s.crs;
    assign LINE_RX_TAKE = s.rx_take;
    assign LINE_TX_DATA = s.tx_data;
    assign LINE_TX_VALID = s.tx_valid;
    assign LINE_TX_ACTIVE = s.tx_active;
    assign MODE = s.mode;

endmodule
`default_nettype wire

// ==== testbench/emd_monitor.sv ====
`timescale 1ns/10ps
`default_nettype none
// Watches the link pins between the device and MAC ends.
module emd_monitor
    import emd_pkg::*;
(
    // Clock and reset.
    input wire logic CLK_SYS,
    input wire logic RSTN,
    // Device status.
    input wire emd_mode_type MODE,
    input wire logic SPEED_100,
    // Link pins.
    input wire logic tx_clk,
    input wire logic tx_en,
    input wire logic [3:0] txd,
    input wire logic rx_clk,
    input wire logic rx_dv,
    input wire logic rx_er,
    input wire logic [3:0] rxd,
    input wire logic crs,
    input wire logic ref_clock_in
);
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RSTN);
    // Rest of one slow clock period once its level has risen.
    sequence slow_rest;
        tx_clk [*4] ##1 !tx_clk [*5] ##1 tx_clk;
    endsequence
    // Rest of one reference period once its level has risen.
    sequence ref_rest;
        ref_clock_in [*3] ##1 !ref_clock_in [*4] ##1 ref_clock_in;
    endsequence
    // The fast and serial clocks share one half period of a cycle.
    wire logic fast = (MODE == EMD_SER) || (MODE == EMD_MII && SPEED_100);

    chk_fast_period: assert property (
        fast && $rose(tx_clk) |=> !tx_clk ##1 tx_clk)
        else $error("fast link clock period wrong");
    chk_slow_period: assert property (
        MODE == EMD_MII && !SPEED_100 && $rose(tx_clk) |=> slow_rest)
        else $error("slow clock period wrong");
    chk_ref_period: assert property (
        $rose(ref_clock_in) |=> ref_rest)
        else $error("reference period wrong");
    chk_rx_clk_match: assert property (rx_clk == tx_clk)
        else $error("receive clock differs from transmit clock");
    chk_rmii_clk_idle: assert property (
        MODE == EMD_RMII |-> !tx_clk && !rx_clk)
        else $error("clock pin toggles in reduced mode");
    chk_serial_unused: assert property (
        MODE == EMD_SER |-> !rx_dv && !rx_er && rxd[3:1] == 3'h0)
        else $error("serial pins used");
    chk_rmii_crs_dv: assert property (
        MODE == EMD_RMII && rx_dv |-> crs)
        else $error("combined carrier missing while valid");
    chk_rx_er_cause: assert property (
        rx_er |-> rx_dv && SPEED_100)
        else $error("receive error without valid fast data");
    chk_rxd_idle: assert property (
        MODE != EMD_SER && !rx_dv |-> rxd == 4'h0)
        else $error("receive data outside valid");
    chk_lane_width: assert property (
        MODE != EMD_MII |-> txd[3:2] == 2'h0 && (MODE == EMD_RMII || !txd[1]))
        else $error("unused lane driven");
    chk_mode_fixed: assert property (
        MODE != EMD_MII |=> MODE == $past(MODE))
        else $error("mode changed without reset");
endmodule
`default_nettype wire

// ==== testbench/testbench.sv ====
`timescale 1ns/10ps
`default_nettype none
// Joins both ends and runs random frames through every mode.
module testbench
    import emd_pkg::*;
;
    localparam int N = 6; // Nibbles checked per frame.
    logic clk_sys = 1'b0;
    logic rstn = 1'b0;
    logic drive = 1'b0; // High while frames are offered.
    logic strap_rmii = 1'b0, strap_serial = 1'b0, speed_100 = 1'b0;
    logic carrier = 1'b0, rx_ok = 1'b0, rx_bad = 1'b0, tx_valid = 1'b0;
    logic [3:0] rx_in = 4'h0, tx_in = 4'h0;
    wire logic rx_take, tx_valid_out, tx_active, tx_take, rx_valid, rx_err;
    wire logic rx_carrier;
    wire logic [3:0] tx_out, rx_data;
    wire emd_mode_type mode;
    int fail_count = 0, num_checks = 0, ti = 0, ri = 0;
    logic [3:0] src [N];
    logic [3:0] got_tx [$], got_rx [$];
    logic got_er [$];

    always #20 clk_sys = ~clk_sys;

    emd_if link();
    emd_phy_dev emd_phy_dev_inst (.CLK_SYS(clk_sys), .RSTN(rstn), .CE(1'b1),
        .STRAP_RMII(strap_rmii), .STRAP_SERIAL(strap_serial),
        .SPEED_100(speed_100), .LINE_CARRIER(carrier), .LINE_RX_VALID(rx_ok),
        .LINE_RX_ERR(rx_bad), .LINE_RX_DATA(rx_in), .LINE_RX_TAKE(rx_take),
        .LINE_TX_DATA(tx_out), .LINE_TX_VALID(tx_valid_out),
        .LINE_TX_ACTIVE(tx_active), .MODE(mode), .link(link));
    emd_mac_host emd_mac_host_inst (.CLK_SYS(clk_sys), .RSTN(rstn), .CE(1'b1),
        .MODE_RMII(strap_rmii), .MODE_SERIAL(strap_serial), .TX_DATA(tx_in),
        .TX_VALID(tx_valid), .TX_TAKE(tx_take), .RX_DATA(rx_data),
        .RX_VALID(rx_valid), .RX_ERR(rx_err), .RX_CARRIER(rx_carrier),
        .link(link));
    emd_monitor emd_monitor_inst (.CLK_SYS(clk_sys), .RSTN(rstn), .MODE(mode),
        .SPEED_100(speed_100), .tx_clk(link.tx_clk), .tx_en(link.tx_en),
        .txd(link.txd), .rx_clk(link.rx_clk), .rx_dv(link.rx_dv),
        .rx_er(link.rx_er), .rxd(link.rxd), .crs(link.crs),
        .ref_clock_in(link.ref_clock_in));

    // Feeds both user sides and gathers the results, off the sampling edge.
    // One spare nibble follows each receive frame so the last lane is never cut.
    always @(negedge clk_sys) begin
        if (tx_take) ti++;
        if (rx_take) ri++;
        tx_valid = drive && ti < N;
        tx_in = src[ti % N];
        rx_ok = drive && ri <= N;
        rx_bad = rx_ok && ri == 2;
        rx_in = src[ri % N];
        carrier = rx_ok && (strap_serial || !strap_rmii);
        if (tx_valid_out) begin
            got_tx.push_back(tx_out);
            check("tx active", 4'h1, {3'h0, tx_active});
        end
        if (rx_valid) begin
            got_rx.push_back(rx_data);
            got_er.push_back(rx_err);
            check("carrier", 4'h1, {3'h0, rx_carrier});
        end
    end

    // Compares one value and counts the outcome.
    task automatic check(input string what, input logic [3:0] exp,
                         input logic [3:0] got);
        num_checks++;
        if (got !== exp) begin
            $display("unexpected %s expected %h seen %h", what, exp, got);
            fail_count++;
        end
    endtask

    // An error is flagged only on the fast rate outside serial mode.
    function automatic logic hit(input int k, input logic se, input logic sp);
        return k == 2 && sp && !se;
    endfunction

    // Resets into one mode, then sends a frame each way.
    task automatic run(input logic rm, input logic se, input logic sp,
                       input emd_mode_type em);
        int k;
        rstn = 1'b0;
        strap_rmii = rm;
        strap_serial = se;
        speed_100 = sp;
        for (k = 0; k < N; k++) src[k] = k < 2 ? {4{k[0]}} : 4'($urandom);
        repeat (20) @(negedge clk_sys);
        got_tx.delete();
        got_rx.delete();
        got_er.delete();
        ti = 0;
        ri = 0;
        rstn = 1'b1;
        repeat (4) @(negedge clk_sys);
        check("mode", {2'h0, em}, {2'h0, mode});
        drive = 1'b1;
        for (k = 0; k < 3000 && (got_tx.size() < N || got_rx.size() < N); k++)
            @(negedge clk_sys);
        drive = 1'b0;
        // Pulling a strap the other way must not move the latched mode.
        // RMII is left alone, as a host mode change stops its reference.
        if (!rm) strap_serial = !se;
        repeat (24) @(negedge clk_sys);
        check("held mode", {2'h0, em}, {2'h0, mode});
        check("tx active", 4'h0, {3'h0, tx_active});
        for (k = 0; k < N; k++) begin
            check("tx nibble", src[k], got_tx[k]);
            check("rx nibble",
                src[k] ^ (hit(k, se, sp) ? EMD_RX_CORRUPT : 4'h0), got_rx[k]);
            check("rx error", {3'h0, hit(k, se, sp)},
                {3'h0, got_er[k]});
        end
        $display("test mode %0d speed %0d done", em, sp);
    endtask

    // Prints the counts and the verdict, then stops.
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Cuts a hang short well after the longest expected run.
    initial begin
        #(40 * 20000);
        fail_count++;
        $display("watchdog expired");
        end_of_test();
    end

    // Every mode, MII at both speeds and serial twice, with serial winning over reduced straps at the end.
    initial begin
        void'($urandom(32'h8654));
        run(1'b0, 1'b0, 1'b1, EMD_MII);
        run(1'b0, 1'b0, 1'b0, EMD_MII);
        run(1'b1, 1'b0, 1'b1, EMD_RMII);
        run(1'b0, 1'b1, 1'b0, EMD_SER);
        run(1'b1, 1'b1, 1'b1, EMD_SER);
        end_of_test();
    end
endmodule
`default_nettype wire
